/* File: src/pms_defines.vh */
// Purpose: Constants for the power mode sequencer.
// Assumes: 125 MHz system clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef PMS_DEFINES_VH
`define PMS_DEFINES_VH
`define PMS_CLK_MHZ 125
`define PMS_OCP_TIMER_US 1000
`define PMS_OCP_CYCLES (`PMS_OCP_TIMER_US * `PMS_CLK_MHZ)
`define PMS_WAKE_US 130
`define PMS_WAKE_CYCLES (`PMS_WAKE_US * `PMS_CLK_MHZ)
`define PMS_ST_STANDBY 2'h0
`define PMS_ST_STANDBY2 2'h1
`define PMS_ST_GENERAL 2'h2
`define PMS_ST_ERROR 2'h3
`define PMS_ADDR_CTRL 4'h0
`define PMS_ADDR_STATUS 4'h1
`define PMS_ADDR_IRQ 4'h2
`define PMS_ADDR_MASK 4'h3
`define PMS_IRQ_OCP 0
`define PMS_IRQ_TSD 1
`define PMS_IRQ_ERR 2
`define PMS_IRQ_PGLOSS 3
`endif

/* File: src/pms_sync.v */
// Purpose: Two flip-flop synchroniser for a bundle of pin levels.
// Assumes: Inputs are asynchronous levels.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps
module pms_sync #(
    parameter WIDTH = 1
) (
    input wire sys_clk_i,
    input wire reset_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1;

    // Two register stages clear the metastability window.
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            stage1 <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // pms_sync

/* File: src/pms_sequencer.v */
// Purpose: Mode and channel-enable sequencer of a three-output regulator.
// Assumes: Analog comparators deliver levels; registers on a plain port.
// Notes: Channel index 0 is buck_channel_one, 1 buck_channel_two, 2 linear.
// Register map, byte wide, reached over the plain register port:
//   0 CTRL    bits 2:0 serial enables for buck_channel_one, buck_channel_two, linear.
//   1 STATUS  bits 7:6 mode, bits 5:3 channel enables, bits 2:0 power good.
//   2 IRQ     sticky events, write one to clear: 0 overcurrent, 1 thermal,
//             2 error entry, 3 power-good loss.
//   3 MASK    same layout as IRQ; irq_o is high while a masked-in bit is set.
//   Other addresses read as zero and ignore writes.
// Mode codes: 0 stand-by, 1 stand-by 2, 2 general, 3 error detection.
// Timing: every pin reaches the state logic two cycles after it changes,
// and the outputs one cycle later again. Serial access opens a fixed
// wake time after main enable rises; the overcurrent timer must run
// uninterrupted for its full count before a fault is declared.
// Hazard: a channel driven by both its pin and its serial bit reads as off,
// so a board that mixes the two sources sees the channel drop.
// Limitation: the wake and overcurrent times are counted in system clock
// cycles; a different clock needs PMS_CLK_MHZ in the defines header changed.
// Limitation: undervoltage only counts while main enable is high, so a
// supply dip with main low leaves the device in stand-by with no event.
// Trade-off: outputs are registered from the next mode, so they move in the
// same cycle as the mode register rather than one cycle after it.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "pms_defines.vh"
module pms_sequencer (
    input wire sys_clk_i,
    input wire reset_i,
    input wire main_enable_pin_i,
    input wire buck1_enable_pin_i,
    input wire buck2_enable_pin_i,
    input wire linear_enable_pin_i,
    input wire [2:0] overcurrent_i,
    input wire thermal_shutdown_i,
    input wire undervoltage_i,
    input wire [2:0] above_85pct_i,
    input wire [2:0] above_75pct_i,
    input wire [2:0] startup_done_i,
    input wire [3:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    output reg [2:0] channel_on_o,
    output reg oscillator_on_o,
    output reg low_reference_block_on_o,
    output reg digital_on_o,
    output reg serial_enable_o,
    output reg buck1_power_good_o,
    output reg buck2_power_good_o,
    output reg linear_power_good_o,
    output reg fault_n_o,
    output reg irq_o
);
    // ------------------------------------------------------------
    // Synchronised inputs
    // ------------------------------------------------------------
    // Synchronised copies of the pins and comparator levels.
    wire [8:0] pins_s;
    wire main_s;
    wire [2:0] ch_pin_s;
    wire [2:0] ocp_s;
    wire tsd_s;
    wire uv_s;
    wire [2:0] hi_s;
    wire [2:0] lo_s;
    wire [2:0] ss_s;

    // All pins and comparator levels cross into the clock domain here.
    pms_sync #(.WIDTH(18)) u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .async_i({startup_done_i, above_75pct_i, above_85pct_i, undervoltage_i, thermal_shutdown_i,
                  overcurrent_i, linear_enable_pin_i, buck2_enable_pin_i, buck1_enable_pin_i,
                  main_enable_pin_i}),
        .sync_o({ss_s, lo_s, hi_s, pins_s})
    );

    // Bit layout of the synchronised pin bundle:
    //   0 main enable, 3:1 channel enable pins, 6:4 overcurrent,
    //   7 thermal shutdown, 8 undervoltage.
    // Unpack the pin bundle.
    assign main_s = pins_s[0];
    assign ch_pin_s = pins_s[3:1];
    assign ocp_s = pins_s[6:4];
    assign tsd_s = pins_s[7];
    assign uv_s = pins_s[8];

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    // Mode register and its next value.
    reg [1:0] state;
    reg [1:0] next_state;
    // Serial-bus channel enables, one bit per channel.
    reg [2:0] serial_ch_en;
    // Wake-up timer; counts only while main enable is high.
    reg [14:0] wake_cnt;
    reg woke;
    // One overcurrent persistence counter per channel.
    reg [16:0] ocp_cnt [0:2];
    reg [2:0] ocp_fire;
    // Interrupt status and mask.
    reg [3:0] irq_status;
    reg [3:0] irq_mask;
    // Internal power good and channel requests.
    reg [2:0] pg;
    reg [2:0] ch_req;
    wire undervolt_reset;
    wire fault;
    wire [3:0] irq_event;
    wire [2:0] pg_out;
    wire pg_loss_ev;
    wire err_entry_ev;
    wire tsd_ev;
    wire ocp_ev;
    wire wr_ctrl;
    wire wr_irq;
    wire wr_mask;

    // Undervoltage only counts while main enable is high.
    assign undervolt_reset = uv_s & main_s;
    // Thermal shutdown is checked alongside; either trips the error state.
    assign fault = (state == `PMS_ST_GENERAL) & (tsd_s | (|ocp_fire));
    assign wr_ctrl = reg_wr_i & (reg_addr_i == `PMS_ADDR_CTRL) & serial_enable_o;
    // Interrupt register writes are always taken.
    assign wr_irq = reg_wr_i & (reg_addr_i == `PMS_ADDR_IRQ);
    assign wr_mask = reg_wr_i & (reg_addr_i == `PMS_ADDR_MASK);

    // ------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------

    // Per-channel request: exactly one source high; both high is left off.
    always @*
    begin
        ch_req = (ch_pin_s ^ serial_ch_en) & {3{main_s}};
    end

    // Mode state machine.
    always @*
    begin
        next_state = state;
        case (state)
            // Stand-by waits for main enable with a healthy supply.
            `PMS_ST_STANDBY:
                if (main_s & ~uv_s)
                    next_state = `PMS_ST_STANDBY2;
            // Stand-by 2 waits for any channel request.
            `PMS_ST_STANDBY2:
                if (|ch_req)
                    next_state = `PMS_ST_GENERAL;
            // General runs the channels until a fault or no request is left.
            `PMS_ST_GENERAL:
                if (fault)
                    next_state = `PMS_ST_ERROR;
                else if (~(|ch_req))
                    next_state = `PMS_ST_STANDBY2;
            // Error holds; only the forced return below leaves it.
            `PMS_ST_ERROR:
                next_state = `PMS_ST_ERROR;
            // Unused codes fall back to stand-by.
            default:
                next_state = `PMS_ST_STANDBY;
        endcase
        if (~main_s | undervolt_reset)
            next_state = `PMS_ST_STANDBY;
    end

    // Mode register; reset lands in stand-by.
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
            state <= `PMS_ST_STANDBY;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // Timers and power good
    // ------------------------------------------------------------

    // Wake-up timer: digital block and reference settle before serial access.
    always @(posedge sys_clk_i)
    begin
        if (reset_i | ~main_s)
        begin
            wake_cnt <= 15'h0000;
            woke <= 1'b0;
        end
        else if (wake_cnt == `PMS_WAKE_CYCLES - 1)
            woke <= 1'b1;
        else
            wake_cnt <= wake_cnt + 15'h0001;
    end

    // Overcurrent persistence timers, one per channel.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_ocp
            always @(posedge sys_clk_i)
            begin
                if (reset_i | (state != `PMS_ST_GENERAL) | ~ocp_s[gi] | tsd_s)
                begin
                    ocp_cnt[gi] <= 17'h00000;
                    ocp_fire[gi] <= 1'b0;
                end
                else if (ocp_cnt[gi] == `PMS_OCP_CYCLES - 1)
                    ocp_fire[gi] <= 1'b1;
                else
                    ocp_cnt[gi] <= ocp_cnt[gi] + 17'h00001;
            end

            // Power good: set above 85 %, drop at or below 75 %, low when off.
            always @(posedge sys_clk_i)
            begin
                if (reset_i | ~channel_on_o[gi])
                    pg[gi] <= 1'b0;
                else if (hi_s[gi])
                    pg[gi] <= 1'b1;
                else if (~lo_s[gi])
                    pg[gi] <= 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Register port and interrupts
    // ------------------------------------------------------------
    // Power-good outputs as a vector, indexed as the channels.
    assign pg_out = {linear_power_good_o, buck2_power_good_o, buck1_power_good_o};
    // A reported power good that drops while its channel is still on.
    assign pg_loss_ev = |(~pg & pg_out & channel_on_o);
    // Error entry is seen once, in the cycle the fault is taken.
    assign err_entry_ev = fault & (state != `PMS_ST_ERROR);
    // Thermal shutdown takes precedence over a pending overcurrent.
    assign tsd_ev = fault & tsd_s;
    // Overcurrent fault only when no thermal event stands beside it.
    assign ocp_ev = fault & ~tsd_s;
    // Event vector in the bit order of the IRQ and MASK registers.
    assign irq_event = {pg_loss_ev, err_entry_ev, tsd_ev, ocp_ev};

    // Serial enable bits are cleared when the serial port is disabled.
    always @(posedge sys_clk_i)
    begin
        if (reset_i | ~serial_enable_o)
            serial_ch_en <= 3'h0;
        else if (wr_ctrl)
            serial_ch_en <= reg_wdata_i[2:0];
    end

    // Sticky status: a new event wins over a write-one clear.
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            irq_status <= 4'h0;
            irq_mask <= 4'h0;
            irq_o <= 1'b0;
        end
        else
        begin
            if (wr_irq)
                irq_status <= (irq_status & ~reg_wdata_i[3:0]) | irq_event;
            else
                irq_status <= irq_status | irq_event;
            if (wr_mask)
                irq_mask <= reg_wdata_i[3:0];
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // Read data stands one cycle after the read strobe; unmapped reads zero.
    always @(posedge sys_clk_i)
    begin
        if (reset_i | ~reg_rd_i)
            reg_rdata_o <= 8'h00;
        else
            case (reg_addr_i)
                `PMS_ADDR_CTRL: reg_rdata_o <= {5'h00, serial_ch_en};
                `PMS_ADDR_STATUS: reg_rdata_o <= {state, channel_on_o, pg};
                `PMS_ADDR_IRQ: reg_rdata_o <= {4'h0, irq_status};
                `PMS_ADDR_MASK: reg_rdata_o <= {4'h0, irq_mask};
                default: reg_rdata_o <= 8'h00;
            endcase
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------

    // Mode outputs are registered from the next mode and the requests; the power-good outputs from pg.
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            channel_on_o <= 3'h0;
            oscillator_on_o <= 1'b0;
            low_reference_block_on_o <= 1'b0;
            digital_on_o <= 1'b0;
            serial_enable_o <= 1'b0;
            buck1_power_good_o <= 1'b0;
            buck2_power_good_o <= 1'b0;
            linear_power_good_o <= 1'b0;
            fault_n_o <= 1'b1;
        end
        else
        begin
            // Channels follow their request only in the general state.
            channel_on_o <= (next_state == `PMS_ST_GENERAL) ? ch_req : 3'h0;
            // Linear-only: oscillator stops once the linear channel has started.
            oscillator_on_o <= (next_state == `PMS_ST_GENERAL) &
                               ~((ch_req == 3'h4) & ss_s[2]);
            low_reference_block_on_o <= (next_state == `PMS_ST_GENERAL);
            // Digital block runs in every mode but stand-by.
            digital_on_o <= (next_state != `PMS_ST_STANDBY);
            // Serial port opens only once the wake time has passed.
            serial_enable_o <= (next_state != `PMS_ST_STANDBY) & woke;
            // Power good follows the internal flags one cycle later.
            buck1_power_good_o <= pg[0];
            buck2_power_good_o <= pg[1];
            linear_power_good_o <= pg[2];
            fault_n_o <= (next_state != `PMS_ST_ERROR);
        end
    end
endmodule // pms_sequencer

/* File: bench/pms_plant.sv */
// Purpose: Model of the three regulator outputs seen by the comparators.
// Assumes: An output ramps to its target in RAMP cycles while its channel is on.
// Notes: droop_i pulls every output below both thresholds.
`timescale 1ns/1ps
module pms_plant #(
    parameter RAMP = 20
) (
    input wire sys_clk_i,
    input wire [2:0] channel_on_i,
    input wire droop_i,
    output reg [2:0] above_85pct_o,
    output reg [2:0] above_75pct_o,
    output reg [2:0] startup_done_o
);
    integer lvl [0:2] = '{0, 0, 0};
    integer k;
    // Ramp each output while on and discharge it at once when off.
    always @(posedge sys_clk_i)
    begin
        for (k = 0; k < 3; k = k + 1)
        begin
            lvl[k] = channel_on_i[k] ? ((lvl[k] < RAMP) ? lvl[k] + 1 : RAMP) : 0;
            above_85pct_o[k] <= !droop_i && (lvl[k] * 100 > RAMP * 85);
            above_75pct_o[k] <= !droop_i && (lvl[k] * 100 > RAMP * 75);
            startup_done_o[k] <= lvl[k] == RAMP;
        end
    end
endmodule // pms_plant

/* File: bench/pms_sequencer_monitor.sv */
// Purpose: Port-level checks of the mode sequencer.
// Assumes: Pin changes reach the outputs three to four cycles later.
// Notes: Bound into every instance of the sequencer.
`timescale 1ns/1ps
module pms_sequencer_monitor (
    input wire sys_clk_i,
    input wire reset_i,
    input wire main_enable_pin_i,
    input wire [2:0] overcurrent_i,
    input wire thermal_shutdown_i,
    input wire undervoltage_i,
    input wire [2:0] startup_done_i,
    input wire [2:0] channel_on_o,
    input wire oscillator_on_o,
    input wire low_reference_block_on_o,
    input wire digital_on_o,
    input wire serial_enable_o,
    input wire buck1_power_good_o,
    input wire buck2_power_good_o,
    input wire linear_power_good_o,
    input wire fault_n_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    wire [2:0] pg = {linear_power_good_o, buck2_power_good_o, buck1_power_good_o};
    // The error state keeps every regulator and the oscillator off.
    err_all_off_a: assert property ((!fault_n_o)[*2] |-> channel_on_o == 3'h0 && !oscillator_on_o
        && !low_reference_block_on_o) else $error("regulator running in error state");
    err_digital_on_a: assert property ((!fault_n_o)[*2] |-> digital_on_o && serial_enable_o)
        else $error("digital block off in error state");
    main_low_off_a: assert property ((!main_enable_pin_i)[*5] |-> channel_on_o == 3'h0
        && !serial_enable_o && fault_n_o) else $error("main enable low but block active");
    serial_main_a: assert property ($rose(serial_enable_o) |-> $past(main_enable_pin_i, 3)
        && $past(main_enable_pin_i, 200)) else $error("serial enabled too early");
    pg_when_off_a: assert property ((channel_on_o == 3'h0)[*3] |-> pg == 3'h0)
        else $error("power good with channels off");
    lin_only_osc_a: assert property ((channel_on_o == 3'h4 && startup_done_i[2])[*6]
        |-> !oscillator_on_o && low_reference_block_on_o) else $error("linear-only gating wrong");
    buck_osc_a: assert property ((channel_on_o[1:0] != 2'h0)[*2] |-> oscillator_on_o
        && low_reference_block_on_o) else $error("buck on without oscillator");
    fault_cause_a: assert property ($fell(fault_n_o) |-> $past(channel_on_o) != 3'h0
        && ($past(thermal_shutdown_i, 2) || $past(overcurrent_i, 400) != 3'h0)) else $error("fault without cause");
    err_release_a: assert property ($rose(fault_n_o) |-> !$past(main_enable_pin_i, 2)
        || $past(undervoltage_i, 2)) else $error("error state left without main toggle");
endmodule // pms_sequencer_monitor
bind pms_sequencer pms_sequencer_monitor mon (.sys_clk_i, .reset_i, .main_enable_pin_i, .overcurrent_i,
    .thermal_shutdown_i, .undervoltage_i, .startup_done_i, .channel_on_o, .oscillator_on_o,
    .low_reference_block_on_o, .digital_on_o, .serial_enable_o, .buck1_power_good_o, .buck2_power_good_o,
    .linear_power_good_o, .fault_n_o);

/* File: bench/tb_pms_sequencer.sv */
// Purpose: Self-checking bench for the mode sequencer.
// Assumes: Wake and protection times as set in the defines header.
// Notes: outs packs fault_n, serial, osc, ref, digital and the channels.
`timescale 1ns/1ps
`include "pms_defines.vh"
module tb_pms_sequencer;
    logic sys_clk_i = 1'b0;
    logic rst = 1'b1, main = 1'b0, thermal_shutdown = 1'b0, uv = 1'b0, droop = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic [2:0] cpin = 3'h0, oc = 3'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, v;
    wire [7:0] rdata;
    wire [2:0] chan, a85, a75, sdone;
    wire osc, vref, dig, ser, pg1, pg2, linear_power_good, fault_n, irq;
    wire [7:0] outs = {fault_n, ser, osc, vref, dig, chan};
    wire [7:0] pgs = {4'h0, irq, linear_power_good, pg2, pg1};
    int n_fail = 0;
    int n_tests = 0;
    pms_sequencer dut (.sys_clk_i(sys_clk_i), .reset_i(rst), .main_enable_pin_i(main),
        .buck1_enable_pin_i(cpin[0]), .buck2_enable_pin_i(cpin[1]), .linear_enable_pin_i(cpin[2]),
        .overcurrent_i(oc), .thermal_shutdown_i(thermal_shutdown), .undervoltage_i(uv), .above_85pct_i(a85),
        .above_75pct_i(a75), .startup_done_i(sdone), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .channel_on_o(chan), .oscillator_on_o(osc),
        .low_reference_block_on_o(vref), .digital_on_o(dig), .serial_enable_o(ser),
        .buck1_power_good_o(pg1), .buck2_power_good_o(pg2), .linear_power_good_o(linear_power_good), .fault_n_o(fault_n),
        .irq_o(irq));
    pms_plant plant (.sys_clk_i(sys_clk_i), .channel_on_i(chan), .droop_i(droop), .above_85pct_o(a85),
        .above_75pct_o(a75), .startup_done_o(sdone));
    // Free-running 125 MHz clock.
    initial
    begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge sys_clk_i);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge sys_clk_i);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        #1 n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Cuts a hang short well after the sequence should have ended.
    initial
    begin
        #320000 n_fail++;
        final_report;
    end
    // Main sequence: wake-up, channel control, protection and release.
    initial
    begin
        cyc(4);
        rst <= 1'b0;
        cyc(2);
        chk("outs", 8'h80, outs);
        @(posedge sys_clk_i);
        main <= 1'b1;
        cyc(100);
        wr(4'h0, 8'h01);
        rd(4'h0, v);
        chk("ctrl", 8'h00, v);
        chk("outs", 8'h88, outs);
        cyc(`PMS_WAKE_CYCLES);
        chk("outs", 8'hc8, outs);
        for (int c = 0; c < 3; c++)
            for (int i = 0; i < 4; i++)
            begin
                @(posedge sys_clk_i);
                cpin <= 3'(i[1]) << c;
                wr(4'h0, 8'(i[0]) << c);
                cyc(8);
                chk("outs", (i[1] ^ i[0]) ? (8'hf8 | (8'h01 << c)) : 8'hc8, outs);
            end
        @(posedge sys_clk_i);
        cpin <= 3'h1;
        wr(4'h0, 8'h00);
        wr(4'h2, 8'hff);
        wr(4'h3, 8'h08);
        cyc(40);
        chk("pg", 8'h01, pgs);
        @(posedge sys_clk_i);
        droop <= 1'b1;
        cyc(8);
        chk("pg", 8'h08, pgs);
        @(posedge sys_clk_i);
        droop <= 1'b0;
        cyc(40);
        chk("pg", 8'h09, pgs);
        wr(4'h2, 8'h08);
        cyc(3);
        chk("pg", 8'h01, pgs);
        @(posedge sys_clk_i);
        cpin <= 3'h4;
        cyc(40);
        chk("outs", 8'hdc, outs);
        @(posedge sys_clk_i);
        cpin <= 3'h5;
        oc <= 3'h1;
        cyc(1000);
        chk("outs", 8'hfd, outs);
        wr(4'h2, 8'hff);
        @(posedge sys_clk_i);
        thermal_shutdown <= 1'b1;
        cyc(10);
        thermal_shutdown <= 1'b0;
        oc <= 3'h0;
        cyc(5);
        chk("outs", 8'h48, outs);
        rd(4'h2, v);
        chk("irq", 8'h06, v & 8'h07);
        @(posedge sys_clk_i);
        cpin <= 3'h3;
        cyc(8);
        chk("outs", 8'h48, outs);
        @(posedge sys_clk_i);
        main <= 1'b0;
        cyc(8);
        chk("outs", 8'h80, outs);
        @(posedge sys_clk_i);
        main <= 1'b1;
        cyc(8);
        chk("outs", 8'hbb, outs);
        @(posedge sys_clk_i);
        uv <= 1'b1;
        cyc(8);
        chk("outs", 8'h80, outs);
        final_report;
    end
endmodule // tb_pms_sequencer
